// ### pmr_board.sv
// Board logic that drives the terms, clocks and pins of the register array.
`timescale 1ns/100ps
module pmr_board #(
	parameter int NUM_CELLS = 10
) (
	input wire logic core_clk_i,
	output logic pin_clk_o,
	output logic preset_o,
	output logic [2*NUM_CELLS-1:0] sum_o,
	output logic [2*NUM_CELLS-1:0] rst_o,
	output logic [2*NUM_CELLS-1:0] clk_o,
	output logic [NUM_CELLS-1:0] oe_o,
	output logic [NUM_CELLS-1:0] in_o
);
	// Clocks rest low from time zero so nothing moves during power-up.
	initial begin
		pin_clk_o = 1'b0;
		preset_o = 1'b0;
		sum_o = '0;
		rst_o = '0;
		clk_o = '0;
		oe_o = '0;
		in_o = '0;
	end
	// Data and preset stand with the clock rise, so the sampling edge sees them set up.
	task automatic rise(input logic [2*NUM_CELLS-1:0] s, m, r, input logic p, pre);
		@(posedge core_clk_i);
		sum_o <= s;
		clk_o <= m;
		pin_clk_o <= p;
		rst_o <= r;
		preset_o <= pre;
		@(posedge core_clk_i);
		clk_o <= '0;
		pin_clk_o <= 1'b0;
		rst_o <= '0;
		preset_o <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic pins(input logic [NUM_CELLS-1:0] d, e);
		@(posedge core_clk_i);
		in_o <= d;
		oe_o <= e;
		@(posedge core_clk_i);
		@(posedge core_clk_i);
	endtask
endmodule // pmr_board

// ### pmr_macro_ff.sv
// One configurable D/T flip-flop of a macrocell.
`timescale 1ns/100ps
module pmr_macro_ff (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic hold_clear_i,
	input wire logic t_mode_i,
	input wire logic pin_clk_sel_i,
	input wire logic pin_clk_i,
	input wire logic clk_term_i,
	input wire logic sum_term_i,
	input wire logic reset_term_i,
	input wire logic preset_term_i,
	output logic rise_o,
	output logic q_o
);

	// ****************************************************************
	// Clock selection and edge detection
	// ****************************************************************
	logic sel_clk;
	logic sel_clk_prev;
	logic sel_rise;
	logic load_val;
	logic next_q;

	assign sel_clk = pin_clk_sel_i ? pin_clk_i : clk_term_i;
	assign sel_rise = sel_clk & ~sel_clk_prev;
	assign load_val = t_mode_i ? (q_o ^ sum_term_i) : sum_term_i;

	// Reset wins over preset, and acts whatever the selected clock does.
	assign next_q = reset_term_i ? 1'b0 :
		!sel_rise ? q_o :
		preset_term_i ? 1'b1 : load_val;

	// ****************************************************************
	// State
	// ****************************************************************
	// The edge is reported in the cycle that captures it, so a preset standing with it is seen.
	assign rise_o = sel_rise & reset_n_i & ~hold_clear_i;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || hold_clear_i) begin
			q_o <= 1'b0;
		end else begin
			q_o <= next_q;
		end
	end

	// The previous level follows the clock during power-up so no edge fires at release.
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			sel_clk_prev <= 1'b0;
		end else begin
			sel_clk_prev <= sel_clk;
		end
	end

endmodule // pmr_macro_ff

// ### pmr_macrocell_regs.sv
// Register array of a programmable logic device with an AXI4-Lite control port.
//
// Summary of operation
// - Twenty flip-flops, two in each of ten output logic cells.
// - Each flip-flop has private data sum, reset and clock terms.
// - Each flip-flop is individually set as D-type or T-type.
// - Each flip-flop clocks from its own clock term or the clock pin.
// - All twenty register values feed back, buried or not.
// - Each I/O pin has its own input path apart from feedback.
// - Each pin's driver is enabled by its own enable term.
// - One shared synchronous preset term forces all registers high.
// - Preset acts only on a rising register clock; board supplies it.
// - Each flip-flop has its own asynchronous reset term.
// - A high reset term clears the flip-flop without waiting for a clock.
// - Power-up clears every register low within the power-up reset time.
// - After power-up, pins show cleared values through configured output polarity.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module pmr_macrocell_regs #(
	parameter int NUM_CELLS = pmr_pkg::NUM_CELLS
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic pin_clk_i,
	input wire logic [2*NUM_CELLS-1:0] sum_term_i,
	input wire logic [2*NUM_CELLS-1:0] reset_term_i,
	input wire logic [2*NUM_CELLS-1:0] clk_term_i,
	input wire logic preset_term_i,
	input wire logic [NUM_CELLS-1:0] oe_term_i,
	input wire logic [NUM_CELLS-1:0] io_in_i,
	output logic [NUM_CELLS-1:0] io_out_o,
	output logic [NUM_CELLS-1:0] io_oe_n_o,
	output logic [NUM_CELLS-1:0] pin_in_o,
	output logic [2*NUM_CELLS-1:0] feedback_o
);

	localparam int NUM_FF = pmr_pkg::FF_PER_CELL * NUM_CELLS;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Merges a write into a word lane by lane.
	function automatic logic [31:0] apply_strb(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_val[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Widens a flip-flop vector to a bus word.
	function automatic logic [31:0] ff_word(input logic [NUM_FF-1:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[NUM_FF-1:0] = v;
		return w;
	endfunction

	// Widens a per-cell vector to a bus word.
	function automatic logic [31:0] cell_word(input logic [NUM_CELLS-1:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[NUM_CELLS-1:0] = v;
		return w;
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [NUM_FF-1:0] t_mode;
	logic [NUM_FF-1:0] clk_sel;
	logic [NUM_CELLS-1:0] out_pol;
	logic [NUM_FF-1:0] ff_q;
	logic [NUM_FF-1:0] ff_rise;
	logic [pmr_pkg::PWRUP_CNT_W-1:0] pwrup_cnt;
	logic pwrup_busy;
	logic preset_seen;
	logic areset_seen;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic wr_hit;
	logic wr_tmode;
	logic wr_clksel;
	logic wr_pol;
	logic wr_status;
	logic [31:0] next_tmode_w;
	logic [31:0] next_clksel_w;
	logic [31:0] next_pol_w;
	logic [31:0] status_clr;
	logic preset_event;
	logic areset_event;
	logic next_preset_seen;
	logic next_areset_seen;
	logic [NUM_CELLS-1:0] pin_level;
	logic [NUM_CELLS-1:0] cell_q0;

	// ****************************************************************
	// Power-up reset sequencing
	// ****************************************************************

	// Registers are held clear for the power-up time after reset release.
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pwrup_cnt <= '0;
			pwrup_busy <= 1'b1;
		end else if (pwrup_busy) begin
			if (pwrup_cnt == pmr_pkg::PWRUP_CNT_W'(pmr_pkg::POWER_UP_RESET_CYCLES - 1)) begin
				pwrup_busy <= 1'b0;
			end
			pwrup_cnt <= pwrup_cnt + 1'b1;
		end
	end

	// ****************************************************************
	// Flip-flop array
	// ****************************************************************
	for (genvar k = 0; k < NUM_FF; k++) begin : g_ff
		pmr_macro_ff u_ff (
			.core_clk_i(core_clk_i),
			.reset_n_i(reset_n_i),
			.hold_clear_i(pwrup_busy),
			.t_mode_i(t_mode[k]),
			.pin_clk_sel_i(clk_sel[k]),
			.pin_clk_i(pin_clk_i),
			.clk_term_i(clk_term_i[k]),
			.sum_term_i(sum_term_i[k]),
			.reset_term_i(reset_term_i[k]),
			.preset_term_i(preset_term_i),
			.rise_o(ff_rise[k]),
			.q_o(ff_q[k])
		);
	end

	assign feedback_o = ff_q;

	// ****************************************************************
	// Pins
	// ****************************************************************

	// The first register of each cell drives the pin through its polarity.
	for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
		assign cell_q0[c] = ff_q[pmr_pkg::FF_PER_CELL * c];
	end

	assign pin_level = cell_q0 ^ out_pol;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			io_out_o <= '0;
			io_oe_n_o <= '1;
			pin_in_o <= '0;
		end else begin
			io_out_o <= pin_level;
			io_oe_n_o <= ~oe_term_i;
			pin_in_o <= io_in_i;
		end
	end

	// ****************************************************************
	// Event flags
	// ****************************************************************
	assign preset_event = preset_term_i & (|ff_rise);
	assign areset_event = |reset_term_i;
	assign status_clr = wr_status ? (wr_data & ff_word('1)) : 32'h0000_0000;

	// A new event wins over a clear in the same cycle.
	assign next_preset_seen = preset_event
		| (preset_seen & ~(status_clr[pmr_pkg::STAT_PRESET_SEEN] & wr_strb[0]));
	assign next_areset_seen = areset_event
		| (areset_seen & ~(status_clr[pmr_pkg::STAT_ARESET_SEEN] & wr_strb[0]));

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			preset_seen <= 1'b0;
			areset_seen <= 1'b0;
		end else begin
			preset_seen <= next_preset_seen;
			areset_seen <= next_areset_seen;
		end
	end

	// ****************************************************************
	// Write decode
	// ****************************************************************
	assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	assign wr_tmode = wr_fire && (wr_addr == pmr_pkg::OFS_TMODE);
	assign wr_clksel = wr_fire && (wr_addr == pmr_pkg::OFS_CLKSEL);
	assign wr_pol = wr_fire && (wr_addr == pmr_pkg::OFS_POLARITY);
	assign wr_status = wr_fire && (wr_addr == pmr_pkg::OFS_STATUS);
	assign wr_hit = (wr_addr == pmr_pkg::OFS_TMODE)
		|| (wr_addr == pmr_pkg::OFS_CLKSEL)
		|| (wr_addr == pmr_pkg::OFS_POLARITY)
		|| (wr_addr == pmr_pkg::OFS_STATE)
		|| (wr_addr == pmr_pkg::OFS_PINS)
		|| (wr_addr == pmr_pkg::OFS_STATUS);
	assign next_tmode_w = apply_strb(ff_word(t_mode), wr_data, wr_strb);
	assign next_clksel_w = apply_strb(ff_word(clk_sel), wr_data, wr_strb);
	assign next_pol_w = apply_strb(cell_word(out_pol), wr_data, wr_strb);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			t_mode <= pmr_pkg::RST_TMODE[NUM_FF-1:0];
			clk_sel <= pmr_pkg::RST_CLKSEL[NUM_FF-1:0];
			out_pol <= pmr_pkg::RST_POLARITY[NUM_CELLS-1:0];
		end else begin
			if (wr_tmode) begin
				t_mode <= next_tmode_w[NUM_FF-1:0];
			end
			if (wr_clksel) begin
				clk_sel <= next_clksel_w[NUM_FF-1:0];
			end
			if (wr_pol) begin
				out_pol <= next_pol_w[NUM_CELLS-1:0];
			end
		end
	end

	// ****************************************************************
	// Write channels
	// ****************************************************************

	// Address and data are taken in either order; the write fires once both are held.
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= pmr_pkg::RESP_OKAY;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				wr_addr <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wr_data <= s_axi_wdata_i;
				wr_strb <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_hit ? pmr_pkg::RESP_OKAY : pmr_pkg::RESP_DECERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Read decode
	// ****************************************************************
	assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr_i)
			pmr_pkg::OFS_TMODE: begin
				rd_mux = ff_word(t_mode);
			end
			pmr_pkg::OFS_CLKSEL: begin
				rd_mux = ff_word(clk_sel);
			end
			pmr_pkg::OFS_POLARITY: begin
				rd_mux = cell_word(out_pol);
			end
			pmr_pkg::OFS_STATE: begin
				rd_mux = ff_word(ff_q);
			end
			pmr_pkg::OFS_PINS: begin
				rd_mux = cell_word(pin_in_o);
				rd_mux[pmr_pkg::PINS_OE_LSB +: NUM_CELLS] = ~io_oe_n_o;
			end
			pmr_pkg::OFS_STATUS: begin
				rd_mux[pmr_pkg::STAT_PWRUP_DONE] = ~pwrup_busy;
				rd_mux[pmr_pkg::STAT_PRESET_SEEN] = preset_seen;
				rd_mux[pmr_pkg::STAT_ARESET_SEEN] = areset_seen;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Read channels
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= pmr_pkg::RESP_OKAY;
		end else begin
			if (rd_fire) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_mux;
				s_axi_rresp_o <= rd_hit ? pmr_pkg::RESP_OKAY : pmr_pkg::RESP_DECERR;
			end
			if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

endmodule // pmr_macrocell_regs

// ### pmr_pkg.sv
// Constants shared by the programmable macrocell register array.
package pmr_pkg;

	// ****************************************************************
	// Array shape
	// ****************************************************************
	localparam int NUM_CELLS = 10;
	localparam int FF_PER_CELL = 2;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFS_TMODE = 8'h00;
	localparam logic [7:0] OFS_CLKSEL = 8'h04;
	localparam logic [7:0] OFS_POLARITY = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	localparam logic [7:0] OFS_PINS = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int PINS_OE_LSB = 16;
	localparam int STAT_PWRUP_DONE = 0;
	localparam int STAT_PRESET_SEEN = 1;
	localparam int STAT_ARESET_SEEN = 2;
	localparam logic [31:0] RST_TMODE = 32'h0000_0000;
	localparam logic [31:0] RST_CLKSEL = 32'h0000_0000;
	localparam logic [31:0] RST_POLARITY = 32'h0000_0000;

	// ****************************************************************
	// Bus answers
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CORE_CLK_PERIOD_NS = 25;
	localparam int POWER_UP_RESET_TIME_NS = 600;
	localparam int POWER_UP_RESET_TIME_MAX_NS = 1000;
	localparam int POWER_UP_RESET_CYCLES = POWER_UP_RESET_TIME_NS / CORE_CLK_PERIOD_NS;
	localparam int PWRUP_CNT_W = 6;

endpackage

// ### pmr_regs_props.sv
// Concurrent checks on the ports of the macrocell register array.
`timescale 1ns/100ps
module pmr_regs_props #(
	parameter int NUM_CELLS = 10
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic pin_clk_i,
	input wire logic [2*NUM_CELLS-1:0] clk_term_i,
	input wire logic [2*NUM_CELLS-1:0] reset_term_i,
	input wire logic preset_term_i,
	input wire logic [NUM_CELLS-1:0] oe_term_i,
	input wire logic [NUM_CELLS-1:0] io_in_i,
	input wire logic [NUM_CELLS-1:0] io_oe_n_o,
	input wire logic [NUM_CELLS-1:0] pin_in_o,
	input wire logic [2*NUM_CELLS-1:0] feedback_o
);
	localparam int NF = 2 * NUM_CELLS;
	logic [5:0] up_cnt;
	logic [NF-1:0] prev_ct;
	logic prev_pc;
	// Flops whose term clock and the pin clock both rise, whatever their selection.
	wire [NF-1:0] all_rise = clk_term_i & ~prev_ct & {NF{pin_clk_i & ~prev_pc}};
	always_ff @(posedge core_clk_i) begin
		prev_ct <= clk_term_i;
		prev_pc <= pin_clk_i;
		if (!reset_n_i)
			up_cnt <= 6'h00;
		else if (up_cnt != 6'h3F)
			up_cnt <= up_cnt + 6'h01;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	a_powerup_clear: assert property (up_cnt <= 6'h18 |-> feedback_o == '0)
		else $error("Flops not clear in power-up hold.");
	a_reset_clears: assert property (|reset_term_i |=> (feedback_o & $past(reset_term_i)) == '0)
		else $error("Reset term did not clear its flop.");
	a_preset_high: assert property (up_cnt > 6'h1E && preset_term_i && |all_rise |=>
		((feedback_o | $past(reset_term_i)) & $past(all_rise)) == $past(all_rise))
		else $error("Preset did not force clocked flops high.");
	a_pin_input: assert property (reset_n_i |=> pin_in_o == $past(io_in_i))
		else $error("Pin input path wrong.");
	a_enable_path: assert property (reset_n_i |=> io_oe_n_o == ~$past(oe_term_i))
		else $error("Pin enable path wrong.");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("Read not answered in one cycle.");
	a_write_answer: assert property (wr_taken |=> !s_axi_awready_o ##[0:2] s_axi_bvalid_o)
		else $error("Write not answered in time.");
	a_read_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
		!s_axi_rvalid_o ##[0:1] s_axi_arready_o)
		else $error("Read channel not released.");
	a_write_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
		!s_axi_bvalid_o ##[0:1] (s_axi_awready_o && s_axi_wready_o))
		else $error("Write channel not released.");
endmodule // pmr_regs_props

bind pmr_macrocell_regs pmr_regs_props #(.NUM_CELLS(NUM_CELLS)) pmr_regs_props_inst (
	.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.pin_clk_i(pin_clk_i), .clk_term_i(clk_term_i), .reset_term_i(reset_term_i),
	.preset_term_i(preset_term_i), .oe_term_i(oe_term_i), .io_in_i(io_in_i),
	.io_oe_n_o(io_oe_n_o), .pin_in_o(pin_in_o), .feedback_o(feedback_o)
);

// ### tb.sv
// Self-checking bench for the macrocell register array.
`timescale 1ns/100ps
module tb;
	localparam int NC = pmr_pkg::NUM_CELLS;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, pin_clk, preset;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [2*NC-1:0] sum, rterm, cterm, fb, q, tm, cs;
	logic [NC-1:0] oe, io_in, io_out, oe_n, pin_in, pl;
	int fail_count, checks_done;
	logic [3:0] strb;
	pmr_macrocell_regs pmr_macrocell_regs_inst (.core_clk_i(clk), .reset_n_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pin_clk_i(pin_clk),
		.sum_term_i(sum), .reset_term_i(rterm), .clk_term_i(cterm), .preset_term_i(preset),
		.oe_term_i(oe), .io_in_i(io_in), .io_out_o(io_out), .io_oe_n_o(oe_n),
		.pin_in_o(pin_in), .feedback_o(fb));
	pmr_board #(.NUM_CELLS(NC)) pmr_board_inst (.core_clk_i(clk), .pin_clk_o(pin_clk),
		.preset_o(preset), .sum_o(sum), .rst_o(rterm), .clk_o(cterm), .oe_o(oe),
		.in_o(io_in));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		strb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic ev(input logic [2*NC-1:0] s, m, r, input logic p, pre);
		logic [2*NC-1:0] e, d;
		logic [NC-1:0] po;
		pmr_board_inst.rise(s, m, r, p, pre);
		e = (~cs & m) | (cs & {2*NC{p}});
		d = pre ? '1 : ((tm & (q ^ s)) | (~tm & s));
		q = ((q & ~e) | (d & e)) & ~r;
		for (int c = 0; c < NC; c++)
			po[c] = q[2*c] ^ pl[c];
		#1;
		chk(32'(fb), 32'(q));
		chk(32'(io_out), 32'(po));
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#(4000 * 25);
		fail_count++;
		tally_and_finish;
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, fail_count, checks_done} = '0;
		strb = 4'h0;
		{q, tm, cs, pl} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk(32'(fb), 32'h0);
		chk(32'(io_out), 32'h0);
		chk(32'(oe_n), 32'({NC{1'b1}}));
		repeat (30) @(posedge clk);
		rdchk(pmr_pkg::OFS_STATUS, 32'h1, pmr_pkg::RESP_OKAY);
		rdchk(pmr_pkg::OFS_TMODE, pmr_pkg::RST_TMODE, pmr_pkg::RESP_OKAY);
		rdchk(pmr_pkg::OFS_CLKSEL, pmr_pkg::RST_CLKSEL, pmr_pkg::RESP_OKAY);
		rdchk(pmr_pkg::OFS_POLARITY, pmr_pkg::RST_POLARITY, pmr_pkg::RESP_OKAY);
		rdchk(8'h18, 32'h0, pmr_pkg::RESP_DECERR);
		tm = 20'hAAAAA;
		cs = 20'h0F0F0;
		pl = 10'h155;
		wr(pmr_pkg::OFS_TMODE, 32'(tm), 4'hF, pmr_pkg::RESP_OKAY);
		wr(pmr_pkg::OFS_CLKSEL, 32'(cs), 4'hF, pmr_pkg::RESP_OKAY);
		wr(pmr_pkg::OFS_POLARITY, 32'(pl), 4'hF, pmr_pkg::RESP_OKAY);
		wr(8'h18, 32'hFFFF_FFFF, 4'hF, pmr_pkg::RESP_DECERR);
		rdchk(pmr_pkg::OFS_TMODE, 32'(tm), pmr_pkg::RESP_OKAY);
		ev(20'hFFFFF, 20'hFFFFF, 20'h0, 1'b0, 1'b0);
		ev(20'h3C3C3, 20'hFFFFF, 20'h0, 1'b1, 1'b0);
		ev(20'h0, 20'h0, 20'h0, 1'b1, 1'b0);
		rdchk(pmr_pkg::OFS_STATE, 32'(q), pmr_pkg::RESP_OKAY);
		ev(20'h0, 20'hFFFFF, 20'h00001, 1'b1, 1'b1);
		ev(20'h0, 20'h0, 20'h0F00F, 1'b0, 1'b0);
		rdchk(pmr_pkg::OFS_STATUS, 32'h7, pmr_pkg::RESP_OKAY);
		wr(pmr_pkg::OFS_STATUS, 32'h6, 4'hF, pmr_pkg::RESP_OKAY);
		rdchk(pmr_pkg::OFS_STATUS, 32'h1, pmr_pkg::RESP_OKAY);
		pmr_board_inst.pins(10'h2A5, 10'h35A);
		#1;
		chk(32'(pin_in), 32'h2A5);
		chk(32'(oe_n), 32'h00A5);
		rdchk(pmr_pkg::OFS_PINS, 32'h035A_02A5, pmr_pkg::RESP_OKAY);
		wr(pmr_pkg::OFS_POLARITY, 32'hFFFF_FFFF, 4'h2, pmr_pkg::RESP_OKAY);
		rdchk(pmr_pkg::OFS_POLARITY, 32'h0000_0355, pmr_pkg::RESP_OKAY);
		tally_and_finish;
	end
endmodule // tb
